// File: downconverter_config_regs.sv
// Configuration and status register bank of the RF down converter
`include "downconv_consts.svh"

module downconverter_config_regs
	import downconv_pkg::*;
#(
	parameter logic [1:0] ID_CODE = `ID_CODE_DEFAULT // Arbitrary value
) (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RESETN_I,
	// Byte port from the serial protocol engine
	input wire logic WR_START_I,
	input wire logic WR_VALID_I,
	input wire logic [7:0] WR_DATA_I,
	input wire logic RD_REQ_I,
	output logic [7:0] RD_DATA_O,
	output logic RD_VALID_O,
	// Analog status pins
	input wire logic PLL_LOCKED_I,
	input wire logic TUNE_DONE_I,
	input wire logic [4:0] VCO_TUNING_WORD_I,
	// Mode and path control
	output logic [4:0] MODE_CODE_O,
	output logic LEVEL_LOOP_TEST_OFF_O,
	output logic PEAK_DETECT_TEST_EN_O,
	output logic RX_CHAIN_ON_O,
	output logic SYNTH_ON_O,
	output logic LOW_OSC_ON_O,
	output logic HIGH_OSC_ON_O,
	output logic EXT_LO_IN_ON_O,
	output logic LO_OUT_BUF_ON_O,
	// Synthesizer settings
	output logic [11:0] FEEDBACK_COUNT_O,
	output logic [4:0] SWALLOW_COUNT_O,
	output logic [9:0] REF_RATIO_O,
	output logic [1:0] VCO_AMPLITUDE_O,
	output logic [2:0] CHARGE_PUMP_CURRENT_O,
	output logic [4:0] PRESCALER_MODULUS_O,
	output logic [16:0] LO_MULT_O,
	output logic LO_HALVE_O,
	// Tuning and silence
	output logic TUNING_ALG_SELECT_O,
	output logic TUNING_TEST_SELECT_O,
	output logic CAL_RUN_O,
	output logic IF_MUTE_O,
	output logic MIXER_MUTE_O,
	output logic LO_OUT_MUTE_O,
	// DAC, mixer, IF amplifier and LO
	output logic [9:0] DAC_WORD_O,
	output logic DAC_SLEEP_O,
	output logic [3:0] GATE_BIAS_O,
	output logic [1:0] IF_AMP_BIAS_O,
	output logic [2:0] TUNE_CAP_O,
	output logic [1:0] LO_AMP_O,
	output logic MUX_LOW_POWER_TEST_O
);

	cfg_state_t q;
	cfg_state_t d;
	logic seq_finish;
	logic seq_run;
	logic data_wr;
	logic sil_wr;
	logic [7:0] status;

	// ********************
	// Tuning sequencer
	// ********************
	tune_sequencer u_tune (
		.clk_i(MCLK_I),
		.rst_n_i(RESETN_I),
		.start_i(q.cal_req),
		.done_i(q.done_sync),
		.run_o(seq_run),
		.finish_o(seq_finish)
	);

	// ********************
	// Next state
	// ********************
	always_comb begin
		d = q;
		data_wr = WR_VALID_I && !WR_START_I && !q.expect_addr;
		sil_wr = data_wr && (q.sub_addr == `OFS_SILENCE);
		status = {ID_CODE, q.lock_sync, q.word_sync};
		// Pins pass two flops before use
		d.lock_meta = PLL_LOCKED_I;
		d.lock_sync = q.lock_meta;
		d.lock_prev = q.lock_sync;
		d.done_meta = TUNE_DONE_I;
		d.done_sync = q.done_meta;
		// Word is only meaningful once tuning has settled, so lane skew is harmless
		d.word_meta = VCO_TUNING_WORD_I;
		d.word_sync = q.word_meta;
		if (WR_START_I) begin
			d.expect_addr = 1'b1;
		end
		if (WR_VALID_I && !data_wr) begin
			d.sub_addr = WR_DATA_I;
			d.expect_addr = 1'b0;
		end
		if (data_wr) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				if (q.sub_addr == 8'(i)) begin
					d.regs[i] = WR_DATA_I;
				end
			end
			d.sub_addr = q.sub_addr + 8'h01;
		end
		// A host write in the same cycle as the finish wins over the self clear
		if (seq_finish && !sil_wr) begin
			d.regs[`OFS_SILENCE][`BIT_TUNE_START] = 1'b0;
		end
		d.cal_req = (sil_wr && WR_DATA_I[`BIT_TUNE_START])
			|| (q.regs[`OFS_MIX_BIAS][`BIT_RECAL_EN] && q.lock_prev && !q.lock_sync);
		d.path = decode_mode(q.regs[`OFS_MODE][5:1]);
		d.presc_mod = q.regs[`OFS_PLL][`BIT_PRESC_SEL] ? `MODULUS_HIGH : `MODULUS_LOW;
		d.lo_mult = 17'(FEEDBACK_COUNT_O) * 17'(d.presc_mod) + 17'(SWALLOW_COUNT_O);
		d.lo_halve = d.path.low_osc_on;
		// Individual mutes act only while the silence function is enabled
		d.if_mute = q.regs[`OFS_SILENCE][`BIT_SIL_EN] && (q.regs[`OFS_SILENCE][`BIT_SIL_IF]
			|| (q.regs[`OFS_SILENCE][`BIT_SIL_UNLOCK] && !q.lock_sync));
		d.mix_mute = q.regs[`OFS_SILENCE][`BIT_SIL_EN] && q.regs[`OFS_SILENCE][`BIT_SIL_MIX];
		d.lo_mute = q.regs[`OFS_SILENCE][`BIT_SIL_EN] && q.regs[`OFS_SILENCE][`BIT_SIL_LO];
		d.rd_valid = RD_REQ_I;
		if (RD_REQ_I) begin
			d.rd_data = status;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ********************
	// Outputs
	// ********************
	assign RD_DATA_O = q.rd_data;
	assign RD_VALID_O = q.rd_valid;
	assign MODE_CODE_O = q.regs[`OFS_MODE][5:1];
	assign LEVEL_LOOP_TEST_OFF_O = q.regs[`OFS_MODE][`BIT_LEVEL_TEST];
	assign PEAK_DETECT_TEST_EN_O = q.regs[`OFS_MODE][`BIT_PEAK_TEST];
	assign RX_CHAIN_ON_O = q.path.rx_on;
	assign SYNTH_ON_O = q.path.synth_on;
	assign LOW_OSC_ON_O = q.path.low_osc_on;
	assign HIGH_OSC_ON_O = q.path.high_osc_on;
	assign EXT_LO_IN_ON_O = q.path.ext_lo_in_on;
	assign LO_OUT_BUF_ON_O = q.path.lo_out_on;
	assign FEEDBACK_COUNT_O = {q.regs[`OFS_MODE][`BIT_FB_TOP], q.regs[`OFS_FB_HIGH],
		q.regs[`OFS_FB_LOW_SWALLOW][7:5]};
	assign SWALLOW_COUNT_O = q.regs[`OFS_FB_LOW_SWALLOW][4:0];
	assign REF_RATIO_O = {q.regs[`OFS_REF_HIGH], q.regs[`OFS_PLL][7:6]};
	assign VCO_AMPLITUDE_O = q.regs[`OFS_PLL][5:4];
	assign CHARGE_PUMP_CURRENT_O = q.regs[`OFS_PLL][3:1];
	assign PRESCALER_MODULUS_O = q.presc_mod;
	assign LO_MULT_O = q.lo_mult;
	assign LO_HALVE_O = q.lo_halve;
	assign TUNING_ALG_SELECT_O = q.regs[`OFS_SILENCE][`BIT_TUNE_ALG];
	assign TUNING_TEST_SELECT_O = q.regs[`OFS_SILENCE][`BIT_TUNE_TEST];
	assign CAL_RUN_O = seq_run;
	assign IF_MUTE_O = q.if_mute;
	assign MIXER_MUTE_O = q.mix_mute;
	assign LO_OUT_MUTE_O = q.lo_mute;
	assign DAC_WORD_O = {q.regs[`OFS_DAC_HIGH], q.regs[`OFS_MIX_BIAS][7:6]};
	assign DAC_SLEEP_O = q.regs[`OFS_MIX_BIAS][`BIT_DAC_SLEEP];
	assign GATE_BIAS_O = q.regs[`OFS_MIX_BIAS][5:2];
	assign IF_AMP_BIAS_O = q.regs[`OFS_IF_LO][7:6];
	assign TUNE_CAP_O = q.regs[`OFS_IF_LO][5:3];
	assign LO_AMP_O = q.regs[`OFS_IF_LO][2:1];
	assign MUX_LOW_POWER_TEST_O = q.regs[`OFS_IF_LO][`BIT_MUX_TEST];

	// ********************
	// Assertions
	// ********************
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RESETN_I);

	a_addr_load: assert property (WR_VALID_I && (WR_START_I || q.expect_addr) |=>
		q.sub_addr == $past(WR_DATA_I) && !q.expect_addr)
		else $error("sub-address not taken from first byte");
	a_byte_store: assert property (data_wr && q.sub_addr < 8'h09 |=>
		q.regs[$past(q.sub_addr[3:0])] == $past(WR_DATA_I) || $past(sil_wr))
		else $error("data byte not stored at sub-address");
	a_addr_incr: assert property (data_wr |=> q.sub_addr == $past(q.sub_addr) + 8'h01)
		else $error("sub-address did not advance");
	a_status_read: assert property (RD_REQ_I |=> RD_VALID_O
		&& RD_DATA_O == {ID_CODE, $past(q.lock_sync), $past(q.word_sync)})
		else $error("read did not return status");
	a_start_clear: assert property (seq_finish && !sil_wr |=> !q.regs[`OFS_SILENCE][`BIT_TUNE_START])
		else $error("start bit not cleared at finish");
	a_write_start: assert property (sil_wr && WR_DATA_I[`BIT_TUNE_START] && !seq_run |-> ##2 seq_run)
		else $error("tuning did not start");
	a_unlock_recal: assert property (q.regs[`OFS_MIX_BIAS][`BIT_RECAL_EN] && q.lock_prev && !q.lock_sync
		&& !seq_run && !q.cal_req |-> ##2 seq_run)
		else $error("no restart after lock loss");
	a_unlock_mute: assert property (q.regs[`OFS_SILENCE][4:3] == 2'h3 && !q.lock_sync |=> IF_MUTE_O)
		else $error("IF not muted while unlocked");
	a_power_down: assert property (MODE_CODE_O == 5'h00 [*2] |-> !RX_CHAIN_ON_O && !SYNTH_ON_O)
		else $error("power down left paths on");
	a_lo_mult: assert property (##1 LO_MULT_O == 17'($past(FEEDBACK_COUNT_O))
		* 17'($past(q.regs[`OFS_PLL][0]) ? 5'h13 : 5'h10) + 17'($past(SWALLOW_COUNT_O)))
		else $error("LO multiplier wrong");
	a_slave_mode: assert property (MODE_CODE_O == 5'h03 [*2] |-> EXT_LO_IN_ON_O && !SYNTH_ON_O)
		else $error("diversity slave decode wrong");

	c_multi_write: cover property (data_wr ##1 data_wr ##1 data_wr);
	c_tune_done: cover property (seq_run ##[1:1000] seq_finish);
	c_unlock_recal: cover property (q.regs[`OFS_MIX_BIAS][0] && q.lock_prev && !q.lock_sync);
	c_read: cover property (RD_REQ_I ##1 RD_VALID_O);

endmodule : downconverter_config_regs

// File: downconv_consts.svh
// Offsets, field positions, reset values and encodings of the down converter register bank
`ifndef DOWNCONV_CONSTS_SVH
`define DOWNCONV_CONSTS_SVH

// ********************
// Register map
// ********************
`define REG_COUNT 9
`define OFS_MODE 8'h00
`define OFS_FB_HIGH 8'h01
`define OFS_FB_LOW_SWALLOW 8'h02
`define OFS_REF_HIGH 8'h03
`define OFS_PLL 8'h04
`define OFS_SILENCE 8'h05
`define OFS_DAC_HIGH 8'h06
`define OFS_MIX_BIAS 8'h07
`define OFS_IF_LO 8'h08
`define OFS_STATUS 8'h09
`define REG_RESET 8'h00

// ********************
// Field positions
// ********************
`define BIT_LEVEL_TEST 7
`define BIT_PEAK_TEST 6
`define BIT_FB_TOP 0
`define BIT_PRESC_SEL 0
`define BIT_TUNE_ALG 7
`define BIT_TUNE_START 6
`define BIT_TUNE_TEST 5
`define BIT_SIL_EN 4
`define BIT_SIL_UNLOCK 3
`define BIT_SIL_LO 2
`define BIT_SIL_MIX 1
`define BIT_SIL_IF 0
`define BIT_DAC_SLEEP 1
`define BIT_RECAL_EN 0
`define BIT_MUX_TEST 0

// ********************
// Encodings
// ********************
`define MODULUS_LOW 5'h10
`define MODULUS_HIGH 5'h13
`define ID_CODE_DEFAULT 2'h1

`endif

// File: downconv_pkg.sv
// Types and mode decoding shared by the down converter register bank
package downconv_pkg;
`include "downconv_consts.svh"

	// ********************
	// Operating modes
	// ********************
	typedef enum logic [4:0] {
		MODE_POWER_DOWN = 5'h00,
		MODE_STD_LOW = 5'h01,
		MODE_STD_HIGH = 5'h02,
		MODE_DIV_SLAVE = 5'h03,
		MODE_MASTER_LOW = 5'h04,
		MODE_MASTER_HIGH = 5'h05,
		MODE_EXT_STD = 5'h06,
		MODE_EXT_MASTER = 5'h07
	} op_mode_t;

	typedef struct packed {
		logic rx_on;
		logic synth_on;
		logic low_osc_on;
		logic high_osc_on;
		logic ext_lo_in_on;
		logic lo_out_on;
	} path_ctrl_t;

	// ********************
	// Tuning sequencer state
	// ********************
	typedef enum logic {
		TUNE_IDLE = 1'b0,
		TUNE_RUN = 1'b1
	} tune_state_t;

	typedef struct packed {
		tune_state_t state;
		logic done_prev;
		logic run;
		logic finish;
	} tune_seq_t;

	// ********************
	// Register bank state
	// ********************
	typedef struct packed {
		logic [`REG_COUNT-1:0][7:0] regs;
		logic [7:0] sub_addr;
		logic expect_addr;
		logic lock_meta;
		logic lock_sync;
		logic lock_prev;
		logic done_meta;
		logic done_sync;
		logic [4:0] word_meta;
		logic [4:0] word_sync;
		logic [7:0] rd_data;
		logic rd_valid;
		path_ctrl_t path;
		logic [4:0] presc_mod;
		logic [16:0] lo_mult;
		logic lo_halve;
		logic if_mute;
		logic mix_mute;
		logic lo_mute;
		logic cal_req;
	} cfg_state_t;

	// Unused codes fall back to everything off, same as power down
	function automatic path_ctrl_t decode_mode(input logic [4:0] code);
		path_ctrl_t p;
		p = '0;
		case (code)
			MODE_STD_LOW: p = '{rx_on: 1'b1, synth_on: 1'b1, low_osc_on: 1'b1, default: 1'b0};
			MODE_STD_HIGH: p = '{rx_on: 1'b1, synth_on: 1'b1, high_osc_on: 1'b1, default: 1'b0};
			MODE_DIV_SLAVE: p = '{rx_on: 1'b1, ext_lo_in_on: 1'b1, default: 1'b0};
			MODE_MASTER_LOW: p = '{rx_on: 1'b1, synth_on: 1'b1, low_osc_on: 1'b1, lo_out_on: 1'b1, default: 1'b0};
			MODE_MASTER_HIGH: p = '{rx_on: 1'b1, synth_on: 1'b1, high_osc_on: 1'b1, lo_out_on: 1'b1, default: 1'b0};
			MODE_EXT_STD: p = '{rx_on: 1'b1, synth_on: 1'b1, ext_lo_in_on: 1'b1, default: 1'b0};
			MODE_EXT_MASTER: p = '{rx_on: 1'b1, synth_on: 1'b1, ext_lo_in_on: 1'b1, lo_out_on: 1'b1, default: 1'b0};
			default: p = '0;
		endcase
		return p;
	endfunction : decode_mode

endpackage : downconv_pkg

// File: tune_sequencer.sv
// VCO tuning run tracker: starts on request, ends on the rising edge of the done level
module tune_sequencer
	import downconv_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic start_i,
	input wire logic done_i,
	// Status
	output logic run_o,
	output logic finish_o
);

	tune_seq_t q;
	tune_seq_t d;

	always_comb begin
		d = q;
		d.finish = 1'b0;
		d.done_prev = done_i;
		case (q.state)
			TUNE_IDLE: begin
				if (start_i) begin
					d.state = TUNE_RUN;
					d.run = 1'b1;
				end
			end
			TUNE_RUN: begin
				// A request while running is dropped: one run already covers it
				if (done_i && !q.done_prev) begin
					d.state = TUNE_IDLE;
					d.run = 1'b0;
					d.finish = 1'b1;
				end
			end
			default: begin
				d.state = TUNE_IDLE;
				d.run = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign run_o = q.run;
	assign finish_o = q.finish;

endmodule : tune_sequencer

// File: downconv_host_model.sv
// Host model that drives the byte port of the register bank like a bus master
module downconv_host_model (
	// Clock
	input wire logic clk_i,
	// Write side
	output logic wr_start_o,
	output logic wr_valid_o,
	output logic [7:0] wr_data_o,
	// Read side
	output logic rd_req_o,
	input wire logic [7:0] rd_data_i,
	input wire logic rd_valid_i
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		wr_start_o = 1'b0;
		wr_valid_o = 1'b0;
		wr_data_o = 8'h00;
		rd_req_o = 1'b0;
	end

	// Sub-address first, then n data bytes; gap idle cycles model a slow host
	task automatic write_burst(input logic [7:0] addr, input logic [7:0] d[16], input int n, input int gap);
		@(negedge clk_i);
		wr_start_o = 1'b1;
		wr_valid_o = 1'b1;
		wr_data_o = addr;
		for (int i = 0; i < n; i++) begin
			repeat (gap) begin
				@(negedge clk_i);
				wr_start_o = 1'b0;
				wr_valid_o = 1'b0;
				wr_data_o = ~wr_data_o;
			end
			@(negedge clk_i);
			wr_start_o = 1'b0;
			wr_valid_o = 1'b1;
			wr_data_o = d[i];
		end
		@(negedge clk_i);
		wr_valid_o = 1'b0;
		// Idle bus shows no stale byte
		wr_data_o = ~wr_data_o;
	endtask : write_burst

	// Plain read, no sub-address
	task automatic read_byte(output logic [7:0] d, output logic v);
		@(negedge clk_i);
		rd_req_o = 1'b1;
		@(negedge clk_i);
		rd_req_o = 1'b0;
		v = rd_valid_i;
		d = rd_data_i;
	endtask : read_byte
endmodule : downconv_host_model

// File: tb_top.sv
// Self-checking testbench of the down converter register bank
`include "downconv_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************
	// Signals
	// ****************
	logic MCLK_I = 1'b0;
	logic RESETN_I = 1'b0;
	logic PLL_LOCKED_I = 1'b0;
	logic TUNE_DONE_I = 1'b0;
	logic [4:0] VCO_TUNING_WORD_I = 5'h00;
	logic WR_START_I, WR_VALID_I, RD_REQ_I, RD_VALID_O, LEVEL_LOOP_TEST_OFF_O, PEAK_DETECT_TEST_EN_O;
	logic [7:0] WR_DATA_I, RD_DATA_O;
	logic RX_CHAIN_ON_O, SYNTH_ON_O, LOW_OSC_ON_O, HIGH_OSC_ON_O, EXT_LO_IN_ON_O, LO_OUT_BUF_ON_O;
	logic [4:0] MODE_CODE_O, SWALLOW_COUNT_O, PRESCALER_MODULUS_O;
	logic [11:0] FEEDBACK_COUNT_O;
	logic [9:0] REF_RATIO_O, DAC_WORD_O;
	logic [1:0] VCO_AMPLITUDE_O, IF_AMP_BIAS_O, LO_AMP_O;
	logic [2:0] CHARGE_PUMP_CURRENT_O, TUNE_CAP_O;
	logic [16:0] LO_MULT_O;
	logic LO_HALVE_O, TUNING_ALG_SELECT_O, TUNING_TEST_SELECT_O, CAL_RUN_O, IF_MUTE_O, MIXER_MUTE_O;
	logic LO_OUT_MUTE_O, DAC_SLEEP_O, MUX_LOW_POWER_TEST_O;
	logic [3:0] GATE_BIAS_O;
	int fails = 0;
	int samples_checked = 0;
	logic [7:0] sh [9];
	logic [7:0] d [16];
	logic [7:0] a, rd;
	logic v;
	int n;
	// Path bits rx, synth, low, high, ext in, lo out per mode code
	logic [5:0] mode_tab [8] = '{6'h00, 6'h38, 6'h34, 6'h22, 6'h39, 6'h35, 6'h32, 6'h33};

	always #2 MCLK_I = ~MCLK_I;

	downconverter_config_regs downconverter_config_regs_inst (.MCLK_I, .RESETN_I, .WR_START_I, .WR_VALID_I,
		.WR_DATA_I, .RD_REQ_I, .RD_DATA_O, .RD_VALID_O, .PLL_LOCKED_I, .TUNE_DONE_I, .VCO_TUNING_WORD_I,
		.MODE_CODE_O, .LEVEL_LOOP_TEST_OFF_O, .PEAK_DETECT_TEST_EN_O, .RX_CHAIN_ON_O, .SYNTH_ON_O,
		.LOW_OSC_ON_O, .HIGH_OSC_ON_O, .EXT_LO_IN_ON_O, .LO_OUT_BUF_ON_O, .FEEDBACK_COUNT_O, .SWALLOW_COUNT_O,
		.REF_RATIO_O, .VCO_AMPLITUDE_O, .CHARGE_PUMP_CURRENT_O, .PRESCALER_MODULUS_O, .LO_MULT_O, .LO_HALVE_O,
		.TUNING_ALG_SELECT_O, .TUNING_TEST_SELECT_O, .CAL_RUN_O, .IF_MUTE_O, .MIXER_MUTE_O, .LO_OUT_MUTE_O,
		.DAC_WORD_O, .DAC_SLEEP_O, .GATE_BIAS_O, .IF_AMP_BIAS_O, .TUNE_CAP_O, .LO_AMP_O, .MUX_LOW_POWER_TEST_O);

	downconv_host_model downconv_host_model_inst (.clk_i(MCLK_I), .wr_start_o(WR_START_I),
		.wr_valid_o(WR_VALID_I), .wr_data_o(WR_DATA_I), .rd_req_o(RD_REQ_I), .rd_data_i(RD_DATA_O),
		.rd_valid_i(RD_VALID_O));

	// ****************
	// Helpers
	// ****************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// Only bytes a well-behaved host may send; start bit left clear here
	function automatic logic [7:0] legal(input int adr, input logic [7:0] x);
		logic [7:0] r;
		r = x;
		if (adr == 0) r = {2'b00, 5'($urandom_range(9)), x[0]};
		if (adr == 5) r = {x[7], 2'b00, x[4], x[3] | x[4], x[2:0]};
		return r;
	endfunction : legal

	task automatic check_all();
		logic [11:0] fb;
		logic [4:0] md, pm;
		logic [5:0] pth;
		logic [16:0] mult;
		logic en;
		fb = {sh[0][0], sh[1], sh[2][7:5]};
		md = sh[0][5:1];
		pth = (md < 5'd8) ? mode_tab[md[2:0]] : 6'h00;
		pm = sh[4][0] ? `MODULUS_HIGH : `MODULUS_LOW;
		mult = fb * pm + sh[2][4:0];
		en = sh[5][4];
		check(MODE_CODE_O, md);
		check({RX_CHAIN_ON_O, SYNTH_ON_O, LOW_OSC_ON_O, HIGH_OSC_ON_O, EXT_LO_IN_ON_O, LO_OUT_BUF_ON_O}, pth);
		check({LEVEL_LOOP_TEST_OFF_O, PEAK_DETECT_TEST_EN_O, TUNING_TEST_SELECT_O}, 3'b000);
		check(FEEDBACK_COUNT_O, fb);
		check(SWALLOW_COUNT_O, sh[2][4:0]);
		check(REF_RATIO_O, {sh[3], sh[4][7:6]});
		check({VCO_AMPLITUDE_O, CHARGE_PUMP_CURRENT_O}, sh[4][5:1]);
		check(PRESCALER_MODULUS_O, pm);
		check({LO_HALVE_O, LO_MULT_O}, {pth[3], mult});
		check(TUNING_ALG_SELECT_O, sh[5][7]);
		check({IF_MUTE_O, MIXER_MUTE_O, LO_OUT_MUTE_O},
			{en & (sh[5][0] | (sh[5][3] & ~PLL_LOCKED_I)), en & sh[5][1], en & sh[5][2]});
		check(DAC_WORD_O, {sh[6], sh[7][7:6]});
		check({GATE_BIAS_O, DAC_SLEEP_O}, sh[7][5:1]);
		check({IF_AMP_BIAS_O, TUNE_CAP_O, LO_AMP_O, MUX_LOW_POWER_TEST_O}, sh[8]);
	endtask : check_all

	task automatic write1(input logic [7:0] adr, input logic [7:0] x);
		d[0] = x;
		downconv_host_model_inst.write_burst(adr, d, 1, 0);
		if (adr < 8'd9) sh[adr] = x;
		repeat (4) @(negedge MCLK_I);
	endtask : write1

	// Bounded wait for the tuning run to reach a level
	task automatic wait_run(input logic lvl);
		int k;
		k = 0;
		while (CAL_RUN_O !== lvl && k < 12) begin
			@(negedge MCLK_I);
			k++;
		end
	endtask : wait_run

	task automatic finish_test();
		$display("Counts: %0d compared, %0d mismatched", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test

	// ****************
	// Tests
	// ****************
	initial begin
		#40000;
		fails++;
		finish_test();
	end

	initial begin
		void'($urandom(32'h1710));
		foreach (sh[i]) sh[i] = 8'h00;
		repeat (3) @(negedge MCLK_I);
		RESETN_I = 1'b1;
		@(negedge MCLK_I);
		check_all();
		check(RD_DATA_O, 8'h00);
		$display("Test reset done");
		// Random bursts, some running past the last writable register
		for (int t = 0; t < 40; t++) begin
			a = 8'($urandom_range(10));
			n = $urandom_range(1, 6);
			for (int i = 0; i < n; i++) begin
				d[i] = legal(a + i, 8'($urandom));
				if (a + i < 9) sh[a + i] = d[i];
			end
			downconv_host_model_inst.write_burst(a, d, n, $urandom_range(2));
			PLL_LOCKED_I = 1'($urandom);
			repeat (4) @(negedge MCLK_I);
			check_all();
		end
		$display("Test bursts done");
		for (int c = 0; c < 10; c++) begin
			write1(8'h00, {2'b00, 5'(c), sh[0][0]});
			check_all();
		end
		$display("Test modes done");
		for (int t = 0; t < 6; t++) begin
			PLL_LOCKED_I = 1'($urandom);
			VCO_TUNING_WORD_I = 5'($urandom);
			repeat (3) @(negedge MCLK_I);
			downconv_host_model_inst.read_byte(rd, v);
			check(v, 1'b1);
			check(rd, {`ID_CODE_DEFAULT, PLL_LOCKED_I, VCO_TUNING_WORD_I});
		end
		$display("Test status done");
		write1(8'h05, 8'h40);
		sh[5] = 8'h00;
		wait_run(1'b1);
		check(CAL_RUN_O, 1'b1);
		write1(8'h05, 8'h40);
		sh[5] = 8'h00;
		TUNE_DONE_I = 1'b1;
		wait_run(1'b0);
		check(CAL_RUN_O, 1'b0);
		repeat (8) @(negedge MCLK_I);
		check(CAL_RUN_O, 1'b0);
		$display("Test tuning done");
		TUNE_DONE_I = 1'b0;
		PLL_LOCKED_I = 1'b1;
		write1(8'h07, sh[7] & 8'hFE);
		PLL_LOCKED_I = 1'b0;
		repeat (10) @(negedge MCLK_I);
		check(CAL_RUN_O, 1'b0);
		PLL_LOCKED_I = 1'b1;
		write1(8'h07, sh[7] | 8'h01);
		PLL_LOCKED_I = 1'b0;
		wait_run(1'b1);
		check(CAL_RUN_O, 1'b1);
		TUNE_DONE_I = 1'b1;
		wait_run(1'b0);
		check(CAL_RUN_O, 1'b0);
		check_all();
		$display("Test recalibration done");
		finish_test();
	end
endmodule : tb_top
